// *** spi_cmd_pkg.sv ***
/*
 * Shared definitions for the mnemonic command interpreter: token kinds,
 * token and read-back carriers, parser states, reset values and counts.
 * Assumes one system clock and a host that delivers one token per handshake.
 */
package spi_cmd_pkg;

    localparam int          N_CHAN         = 2;
    localparam int          BYTE_W         = 8;
    localparam int          DIV_W          = 8;
    localparam int          SYNC_DEPTH     = 3;
    localparam int          EDGE_W         = 4;

    // Half period of the serial clock in system cycles
    localparam int          HALF_CYC_DEF   = 4;

    localparam logic [EDGE_W-1:0] LAST_EDGE = 4'hF;
    localparam logic [N_CHAN-1:0] CS_RESET  = 2'h3;
    localparam logic [N_CHAN-1:0] SCLK_RESET = 2'h0;
    localparam logic [BYTE_W-1:0] PINS_RESET = 8'h00;
    localparam logic [BYTE_W-1:0] READ_FILL  = 8'h00;

    typedef enum logic [3:0] {
        TK_SPI, TK_GEN, TK_CH1, TK_CH2,
        TK_MODE0, TK_MODE1, TK_MODE2, TK_MODE3,
        TK_CS_LOW, TK_CS_HIGH, TK_READ, TK_WRITE, TK_PINS
    } tok_kind_e;

    typedef struct packed {
        tok_kind_e         kind;
        logic [BYTE_W-1:0] data;
        logic              last;
    } tok_s;

    typedef struct packed {
        logic              valid;
        logic [BYTE_W-1:0] data;
    } rd_s;

    typedef enum logic [2:0] {
        P_START, P_CHAN, P_MODE, P_BODY, P_GEN, P_XFER
    } parse_e;

endpackage

// *** spi_cmd_interp.sv ***
/*
 * Mnemonic command interpreter driving two serial master channels and an
 * eight-bit control pin word. Assumes tokens come from logic on i_clk and
 * that the serial data inputs come from outside and need synchronising.
 */
// Operation
// - A serial command must open with the serial keyword; an opening other than the serial or general keyword is refused.
// - The second token picks the first or the second channel.
// - The third token picks one of four clock polarity and phase modes for the command.
// - The low-select token drives the chosen channel's chip select low.
// - The high-select token drives the chosen channel's chip select high.
// - A byte token shifts eight bits out, and the read token clocks eight bits in and returns them.
// - Idle-low first-edge mode rests low, samples on rising and changes on falling edges.
// - Idle-low second-edge mode rests low, samples on falling and changes on rising edges.
// - Idle-high first-edge mode rests high, samples on falling and changes on rising edges.
// - Idle-high second-edge mode rests high, samples on rising and changes on falling edges.
// - A general command must open with the general keyword.
// - The pin-word command sets eight control outputs, bit 7 the eighth pin, bit 0 the first.
// - A pin word of zero turns all pins off and a word of three turns on only the first two.
`timescale 1ns/1ps

module spi_cmd_interp
    import spi_cmd_pkg::*;
#(
    parameter logic [DIV_W-1:0] HALF_CYC = DIV_W'(HALF_CYC_DEF)
) (
    input  wire logic              i_clk,
    input  wire logic              i_resetn,
    input  wire logic              i_tok_valid,
    input  wire tok_s              i_tok,
    output logic                   o_tok_ready,
    output rd_s                    o_rd,
    output logic                   o_err,
    output logic [N_CHAN-1:0]      o_sclk,
    output logic [N_CHAN-1:0]      o_mosi,
    output logic [N_CHAN-1:0]      o_cs_n,
    input  wire logic [N_CHAN-1:0] i_miso,
    output logic [BYTE_W-1:0]      o_ctrl_pins
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        parse_e                               parse;
        logic                                 ch;
        logic [N_CHAN-1:0]                    cpol;
        logic [N_CHAN-1:0]                    cpha;
        logic [N_CHAN-1:0]                    sclk;
        logic [N_CHAN-1:0]                    mosi;
        logic [N_CHAN-1:0]                    cs_n;
        logic [N_CHAN-1:0][SYNC_DEPTH-1:0]    sync;
        logic [N_CHAN-1:0]                    miso;
        logic [DIV_W-1:0]                     div;
        logic [EDGE_W-1:0]                    edge_cnt;
        logic [BYTE_W-1:0]                    tx;
        logic [BYTE_W-1:0]                    rx;
        logic                                 is_read;
        logic                                 last;
        rd_s                                  rd;
        logic                                 err;
        logic [BYTE_W-1:0]                    pins;
    } state_s;

    state_s s;
    state_s next_s;
    logic   acc;
    logic   tick;
    logic   lead;
    logic   out_edge;
    logic [N_CHAN-1:0] miso_now;

    assign o_tok_ready = (s.parse != P_XFER);
    assign acc         = i_tok_valid && o_tok_ready;
    assign o_rd        = s.rd;
    assign o_err       = s.err;
    assign o_sclk      = s.sclk;
    assign o_mosi      = s.mosi;
    assign o_cs_n      = s.cs_n;
    assign o_ctrl_pins = s.pins;

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_s          = s;
        next_s.rd.valid = 1'b0;
        next_s.err      = 1'b0;
        tick            = 1'b0;
        lead            = ~s.edge_cnt[0];
        out_edge        = s.cpha[s.ch] ? lead : ~lead;

        // Data inputs count once the second and third stages agree; the agreed
        // value is used at once, otherwise a four-cycle half period lands late
        for (int c = 0; c < N_CHAN; c++) begin
            next_s.sync[c] = {s.sync[c][SYNC_DEPTH-2:0], i_miso[c]};
            if (s.sync[c][SYNC_DEPTH-1] == s.sync[c][SYNC_DEPTH-2]) begin
                miso_now[c] = s.sync[c][SYNC_DEPTH-1];
            end else begin
                miso_now[c] = s.miso[c];
            end
            next_s.miso[c] = miso_now[c];
        end

        unique case (s.parse)
            P_START: begin
                if (acc) begin
                    if (i_tok.kind == TK_SPI) begin
                        next_s.parse = P_CHAN;
                    end else if (i_tok.kind == TK_GEN) begin
                        next_s.parse = P_GEN;
                    end else begin
                        next_s.err = 1'b1;
                    end
                end
            end
            P_CHAN: begin
                if (acc) begin
                    if (i_tok.kind == TK_CH1 || i_tok.kind == TK_CH2) begin
                        next_s.ch    = (i_tok.kind == TK_CH2);
                        next_s.parse = P_MODE;
                    end else begin
                        next_s.err   = 1'b1;
                        next_s.parse = P_START;
                    end
                end
            end
            P_MODE: begin
                if (acc) begin
                    next_s.parse = P_BODY;
                    unique case (i_tok.kind)
                        TK_MODE0: {next_s.cpol[s.ch], next_s.cpha[s.ch]} = 2'h0;
                        TK_MODE1: {next_s.cpol[s.ch], next_s.cpha[s.ch]} = 2'h1;
                        TK_MODE2: {next_s.cpol[s.ch], next_s.cpha[s.ch]} = 2'h2;
                        TK_MODE3: {next_s.cpol[s.ch], next_s.cpha[s.ch]} = 2'h3;
                        default: begin
                            next_s.err   = 1'b1;
                            next_s.parse = P_START;
                        end
                    endcase
                    // Clock rests at the chosen polarity before any byte
                    next_s.sclk[s.ch] = next_s.cpol[s.ch];
                end
            end
            P_BODY: begin
                if (acc) begin
                    if (i_tok.last) begin
                        next_s.parse = P_START;
                    end
                    unique case (i_tok.kind)
                        TK_CS_LOW:  next_s.cs_n[s.ch] = 1'b0;
                        TK_CS_HIGH: next_s.cs_n[s.ch] = 1'b1;
                        TK_WRITE, TK_READ: begin
                            next_s.parse    = P_XFER;
                            next_s.is_read  = (i_tok.kind == TK_READ);
                            next_s.last     = i_tok.last;
                            next_s.div      = '0;
                            next_s.edge_cnt = '0;
                            next_s.tx       = next_s.is_read ? READ_FILL : i_tok.data;
                            // First-edge modes present the first bit before the first edge
                            if (!s.cpha[s.ch]) begin
                                next_s.mosi[s.ch] = next_s.tx[BYTE_W-1];
                                next_s.tx = {next_s.tx[BYTE_W-2:0], 1'b0};
                            end
                        end
                        default: begin
                            next_s.err   = 1'b1;
                            next_s.parse = P_START;
                        end
                    endcase
                end
            end
            P_GEN: begin
                if (acc) begin
                    next_s.parse = P_START;
                    if (i_tok.kind == TK_PINS) begin
                        next_s.pins = i_tok.data;
                    end else begin
                        next_s.err = 1'b1;
                    end
                end
            end
            P_XFER: begin
                if (s.div == HALF_CYC - 1'b1) begin
                    next_s.div = '0;
                    tick       = 1'b1;
                end else begin
                    next_s.div = s.div + 1'b1;
                end
                if (tick) begin
                    // Sixteen toggles give eight pulses and leave the clock at rest
                    next_s.sclk[s.ch] = ~s.sclk[s.ch];
                    next_s.edge_cnt   = s.edge_cnt + 1'b1;
                    if (out_edge) begin
                        next_s.mosi[s.ch] = s.tx[BYTE_W-1];
                        next_s.tx = {s.tx[BYTE_W-2:0], 1'b0};
                    end else begin
                        next_s.rx = {s.rx[BYTE_W-2:0], miso_now[s.ch]};
                    end
                    if (s.edge_cnt == LAST_EDGE) begin
                        next_s.parse   = s.last ? P_START : P_BODY;
                        next_s.rd.valid = s.is_read;
                        next_s.rd.data  = next_s.rx;
                    end
                end
            end
            default: begin
                next_s.parse = P_START;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            s      <= '0;
            s.cs_n <= CS_RESET;
            s.sclk <= SCLK_RESET;
            s.pins <= PINS_RESET;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    reset_state_a: assert property (disable iff (1'b0) !i_resetn |=>
        o_cs_n == CS_RESET && o_sclk == SCLK_RESET && o_ctrl_pins == PINS_RESET)
        else $error("reset state wrong");

    bad_open_a: assert property (s.parse == P_START && acc &&
        i_tok.kind != TK_SPI && i_tok.kind != TK_GEN |=> o_err && s.parse == P_START)
        else $error("bad opening not refused");

    chan_pick_a: assert property (s.parse == P_CHAN && acc && i_tok.kind == TK_CH2
        |=> s.ch && s.parse == P_MODE)
        else $error("second channel not selected");

    mode_rest_a: assert property (s.parse == P_MODE && acc && i_tok.kind == TK_MODE2
        |=> o_sclk[s.ch] && s.cpol[s.ch] && !s.cpha[s.ch])
        else $error("idle level not set by mode");

    cs_low_a: assert property (s.parse == P_BODY && acc && i_tok.kind == TK_CS_LOW
        |=> !o_cs_n[$past(s.ch)])
        else $error("select not driven low");

    cs_high_a: assert property (s.parse == P_BODY && acc && i_tok.kind == TK_CS_HIGH
        |=> o_cs_n[$past(s.ch)])
        else $error("select not driven high");

    read_back_a: assert property (s.parse == P_BODY && acc && i_tok.kind == TK_READ
        |=> !o_rd.valid [*8] ##[1:1000] o_rd.valid)
        else $error("read byte not returned");

    sample_hold_a: assert property (s.parse == P_XFER && $changed(o_sclk[s.ch]) &&
        o_sclk[s.ch] == ~(s.cpol[s.ch] ^ s.cpha[s.ch]) |-> $stable(o_mosi[s.ch]))
        else $error("data moved on sampling edge");

    cs_steady_a: assert property (s.parse == P_XFER && $past(s.parse) == P_XFER
        |-> $stable(o_cs_n))
        else $error("select moved during byte");

    pins_set_a: assert property (s.parse == P_GEN && acc && i_tok.kind == TK_PINS
        |=> o_ctrl_pins == $past(i_tok.data) && s.parse == P_START)
        else $error("pin word not applied");

    pins_hold_a: assert property (!(s.parse == P_GEN && acc && i_tok.kind == TK_PINS)
        |=> $stable(o_ctrl_pins))
        else $error("pin word moved without command");

    pin_zero_a: assert property (s.parse == P_GEN && acc && i_tok.kind == TK_PINS
        && i_tok.data == '0 |=> o_ctrl_pins == '0)
        else $error("zero word left a pin on");

    mode_zero_a: assert property (s.parse == P_MODE && acc && i_tok.kind == TK_MODE0
        |=> !o_sclk[s.ch] && !s.cpol[s.ch] && !s.cpha[s.ch])
        else $error("first mode not set");

    mode_one_a: assert property (s.parse == P_MODE && acc && i_tok.kind == TK_MODE1
        |=> !o_sclk[s.ch] && !s.cpol[s.ch] && s.cpha[s.ch])
        else $error("second mode not set");

    mode_three_a: assert property (s.parse == P_MODE && acc && i_tok.kind == TK_MODE3
        |=> o_sclk[s.ch] && s.cpol[s.ch] && s.cpha[s.ch])
        else $error("fourth mode not set");

    gen_open_a: assert property (s.parse == P_START && acc && i_tok.kind == TK_GEN
        |=> s.parse == P_GEN && !o_err)
        else $error("general keyword not taken");

    clock_rest_a: assert property (s.parse != P_XFER && !(s.parse == P_MODE && acc)
        |=> $stable(o_sclk))
        else $error("clock moved outside a byte");

endmodule // spi_cmd_interp

// *** spi_slave_model.sv ***
/*
 * Behavioural serial slave for one channel: samples the data line and
 * shifts a byte back in the mode it is given.
 * Assumes the bench sets mode and byte while chip select is high.
 */
`timescale 1ns/1ps

module spi_slave_model (
    input  wire logic       i_sclk,
    input  wire logic       i_mosi,
    input  wire logic       i_cs_n,
    input  wire logic       i_cpol,
    input  wire logic       i_cpha,
    input  wire logic [7:0] i_tx,
    output logic            o_miso,
    output logic [7:0]      o_rx,
    output logic [7:0]      o_bits
);
    logic [7:0] sr;
    logic       cs_q;

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        sr = 8'h00;
        cs_q = 1'b1;
        o_miso = 1'b0;
        o_rx = 8'h00;
        o_bits = 8'h00;
    end

    // One process owns every output, so no variable has two drivers
    always @(i_sclk or i_cs_n) begin
        if (i_cs_n !== cs_q) begin
            cs_q = i_cs_n;
            if (i_cs_n === 1'b0) begin
                sr = i_tx;
                o_bits = 8'h00;
                if (!i_cpha) begin
                    o_miso = i_tx[7];
                end
            end else begin
                // Released line shows the inverse of the last bit, never a held copy
                o_miso = ~o_miso;
            end
        end else if (i_cs_n === 1'b0) begin
            if (i_sclk === (i_cpol ~^ i_cpha)) begin
                o_rx = {o_rx[6:0], i_mosi};
                o_bits = o_bits + 8'h01;
            end else if (i_cpha) begin
                o_miso = sr[7];
                sr = {sr[6:0], sr[7]};
            end else begin
                sr = {sr[6:0], sr[7]};
                o_miso = sr[7];
            end
        end
    end
endmodule // spi_slave_model

// *** spi_mnemonic_cmd_interp_tb.sv ***
/*
 * Self-checking bench for the command interpreter: pin words, sequence
 * errors and a write plus read in every mode on both channels.
 * Assumes a slave model per channel and the default serial half period of four cycles.
 */
`timescale 1ns/1ps

`define CHECK_EQ(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin err_count++; \
    $display("unexpected %s expected %h seen %h", nm, exp, got); end end

module spi_mnemonic_cmd_interp_tb;
    import spi_cmd_pkg::*;

    logic              i_clk = 1'b0;
    logic              i_resetn = 1'b0;
    logic              i_tok_valid = 1'b0;
    tok_s              i_tok = '0;
    logic [N_CHAN-1:0] i_miso;
    logic              o_tok_ready;
    rd_s               o_rd;
    logic              o_err;
    logic [N_CHAN-1:0] o_sclk, o_mosi, o_cs_n;
    logic [BYTE_W-1:0] o_ctrl_pins;
    logic [N_CHAN-1:0] cpol = '0, cpha = '0;
    logic [7:0]        tx [N_CHAN];
    logic [7:0]        rx [N_CHAN];
    logic [7:0]        bits [N_CHAN];
    logic [7:0]        wr;
    logic [7:0]        pv [4] = '{8'h00, 8'h03, 8'h80, 8'hFF};
    logic              seen_err;
    int                err_count = 0;
    int                checks_done = 0;

    always #10 i_clk = ~i_clk;

    ////////////////////////////////////////////////////////////////////////////
    spi_cmd_interp #(.HALF_CYC(8'h04)) dut_u (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_tok_valid(i_tok_valid), .i_tok(i_tok),
        .o_tok_ready(o_tok_ready), .o_rd(o_rd), .o_err(o_err), .o_sclk(o_sclk),
        .o_mosi(o_mosi), .o_cs_n(o_cs_n), .i_miso(i_miso), .o_ctrl_pins(o_ctrl_pins));

    for (genvar c = 0; c < N_CHAN; c++) begin : slv
        spi_slave_model u (.i_sclk(o_sclk[c]), .i_mosi(o_mosi[c]), .i_cs_n(o_cs_n[c]),
            .i_cpol(cpol[c]), .i_cpha(cpha[c]), .i_tx(tx[c]), .o_miso(i_miso[c]),
            .o_rx(rx[c]), .o_bits(bits[c]));
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        if (err_count == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic send(input tok_kind_e k, input logic [7:0] d, input logic l);
        int n;
        n = 0;
        @(posedge i_clk);
        i_tok_valid <= 1'b1;
        i_tok <= '{kind: k, data: d, last: l};
        do begin
            @(negedge i_clk);
            n++;
        end while (o_tok_ready !== 1'b1 && n < 400);
        if (n >= 400) begin
            err_count++;
            $display("unexpected token ready expected 1 seen 0");
            finish_test();
        end
        @(posedge i_clk);
        i_tok_valid <= 1'b0;
        @(negedge i_clk);
        seen_err = o_err;
    endtask

    task automatic wait_rd;
        int n;
        n = 0;
        while (o_rd.valid !== 1'b1 && n < 300) begin
            @(negedge i_clk);
            n++;
        end
        `CHECK_EQ("read valid", 1'b1, o_rd.valid)
        if (o_rd.valid !== 1'b1) begin
            finish_test();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        tx = '{8'h00, 8'h00};
        repeat (3) @(posedge i_clk);
        i_resetn <= 1'b1;
        @(negedge i_clk);
        `CHECK_EQ("cs after reset", 2'h3, o_cs_n)
        `CHECK_EQ("sclk after reset", 2'h0, o_sclk)
        `CHECK_EQ("pins after reset", 8'h00, o_ctrl_pins)
        for (int i = 0; i < 4; i++) begin
            send(TK_GEN, 8'h00, 1'b0);
            send(TK_PINS, pv[(i + 1) % 4], 1'b1);
            `CHECK_EQ("pin word", pv[(i + 1) % 4], o_ctrl_pins)
        end
        send(TK_PINS, 8'h55, 1'b1);
        `CHECK_EQ("pins without keyword", 1'b1, seen_err)
        `CHECK_EQ("pins kept", 8'h00, o_ctrl_pins)
        send(TK_GEN, 8'h00, 1'b0);
        send(TK_SPI, 8'h00, 1'b1);
        `CHECK_EQ("general without pin word", 1'b1, seen_err)
        send(TK_CH1, 8'h00, 1'b0);
        `CHECK_EQ("missing serial keyword", 1'b1, seen_err)
        send(TK_SPI, 8'h00, 1'b0);
        send(TK_MODE0, 8'h00, 1'b0);
        `CHECK_EQ("missing channel", 1'b1, seen_err)
        send(TK_SPI, 8'h00, 1'b0);
        send(TK_CH1, 8'h00, 1'b0);
        send(TK_CS_LOW, 8'h00, 1'b0);
        `CHECK_EQ("missing mode", 1'b1, seen_err)
        `CHECK_EQ("select kept", 2'h3, o_cs_n)
        for (int c = 1; c >= 0; c--) begin
            for (int m = 3; m >= 0; m--) begin
                wr = 8'hA5 ^ 8'(c * 4 + m);
                tx[c] = ~wr;
                cpol[c] = m[1];
                cpha[c] = m[0];
                send(TK_SPI, 8'h00, 1'b0);
                send(c ? TK_CH2 : TK_CH1, 8'h00, 1'b0);
                send(tok_kind_e'(4'(TK_MODE0) + 4'(m)), 8'h00, 1'b0);
                `CHECK_EQ("idle clock", m[1], o_sclk[c])
                send(TK_CS_LOW, 8'h00, 1'b0);
                `CHECK_EQ("select low", ~(2'h1 << c), o_cs_n)
                send(TK_WRITE, wr, 1'b0);
                send(TK_READ, 8'h00, 1'b0);
                `CHECK_EQ("byte at slave", wr, rx[c])
                wait_rd();
                `CHECK_EQ("read byte", ~wr, o_rd.data)
                `CHECK_EQ("read fill", READ_FILL, rx[c])
                `CHECK_EQ("sample edges", 8'h10, bits[c])
                `CHECK_EQ("clock back idle", m[1], o_sclk[c])
                send(TK_CS_HIGH, 8'h00, 1'b1);
                `CHECK_EQ("select high", 2'h3, o_cs_n)
            end
        end
        finish_test();
    end
endmodule // spi_mnemonic_cmd_interp_tb
